//--- rtl/psl_pkg.sv
// constants shared by both ends of the passive serial loader
// assumes a 25 MHz system clock on both ends
package psl_pkg;
    localparam int unsigned CLK_NS           = 40;     // sys_clk period
    localparam int unsigned CFG_REQ_LOW_US   = 2;      // least request low
    localparam int unsigned ST_LOW_MIN_US    = 268;    // least status pulse
    localparam int unsigned ST_LOW_MAX_US    = 1506;   // longest status pulse
    localparam int unsigned ST_TO_CLK_US     = 2;      // status high to clk
    localparam int unsigned CD2UM_MIN_US     = 175;    // done to user mode
    localparam int unsigned INIT_CYCLES      = 8576;   // startup clock count
    localparam int unsigned STRB_MIN_NS      = 250;    // strobe least width
    localparam int unsigned CF2CD_MAX_NS     = 600;    // request to low
    // cycle counts: least times round up
    localparam int unsigned CFG_REQ_LOW_CYC  =
        (CFG_REQ_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ST_LOW_CYC       =
        (ST_LOW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ST_TO_CLK_CYC    =
        (ST_TO_CLK_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CD2UM_CYC        =
        (CD2UM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned STRB_MIN_CYC     =
        (STRB_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CF2CD_MAX_CYC    = CF2CD_MAX_NS / CLK_NS;
    localparam int unsigned CLK_HALF_CYC     = 2;      // host divider half
    localparam int unsigned CNT_W            = 20;     // timer width
    localparam int unsigned START_EDGES      = 2;      // extra falling edges
endpackage

//--- rtl/psl_link_if.sv
// passive serial link between host and device
// assumes the bench resolves open-drain lines from the enables
`timescale 1ns/100ps
`default_nettype none
interface psl_link_if;
    logic cfg_req_n;        // host request, low starts a load
    logic status_n_o;       // device pulls status low
    logic status_n_oe;      // device drive enable of status
    logic status_n;         // resolved status line
    logic load_complete;    // device load complete
    logic serial_cfg_clk;   // host-driven serial clock
    logic serial_cfg_bit;   // host serial data
    logic user_startup_clk; // optional initialization clock
    modport dev  (input cfg_req_n, output status_n_o, output status_n_oe,
                  input status_n, output load_complete,
                  input serial_cfg_clk, input serial_cfg_bit,
                  input user_startup_clk);
    modport host (output cfg_req_n, input status_n, input load_complete,
                  output serial_cfg_clk, output serial_cfg_bit,
                  output user_startup_clk);
endinterface
`default_nettype wire

//--- rtl/psl_device.sv
// device end of the passive serial loader: receives the bitstream
// assumes link pins are asynchronous and pass two flops before use
//
// Functional notes
// - user mode keeps request, status, done high
// - request low starts a new load
// - status low during power-on delay
// - load complete low until load done
// - host sends the whole bitstream
// - load complete rises after all bits
// - host gives two falling edges after done
// - host parks clock at fixed level
// - data pin released after configuration
// - init done low until initialization ends
// - done and status low within 600 ns
// - host holds request low 2 us
// - status low pulse 268 to 1506 us
// - status high by 1506 us after request
// - host waits after status high
// - sample data on rising clock edge
// - oscillator init: user mode 175-437 us
// - startup clock enabled, 8576 cycles
// - initialization takes 8576 clock cycles
// - startup clock used only when optioned
// - reconfigure strobe held 250 ns
// - watchdog reset strobe held 250 ns
`timescale 1ns/100ps
`default_nettype none
module psl_device
    import psl_pkg::*;
#(
    parameter int unsigned BITS       = 64,           // bitstream length
    parameter int unsigned POR_CYC    = ST_LOW_CYC,   // power-on delay
    parameter int unsigned STLOW_CYC  = ST_LOW_CYC,   // status pulse
    parameter int unsigned OSC_CYC    = CD2UM_CYC,    // oscillator init
    parameter int unsigned INIT_CNT   = INIT_CYCLES   // startup count
) (
    // clock, reset, enable
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          clk_en,
    // link
    psl_link_if.dev            link,
    // options and user strobes
    input  wire logic          startup_clk_opt,
    input  wire logic          init_done_opt,
    input  wire logic          reconfig_strobe,
    input  wire logic          wdog_reset_strobe,
    // user side
    output logic               user_mode,
    output logic               init_done_n,
    output logic               data_pin_free,
    output logic               bit_valid,
    output logic               bit_value,
    output logic               wdog_kick
);
    typedef enum logic [2:0] {
        S_POR, S_CLEAR, S_LOAD, S_START, S_INIT, S_USER
    } psl_dev_st_t;

    typedef struct packed {
        psl_dev_st_t  st;        // main state
        logic [2:0]   req_s;     // request sync plus history
        logic [2:0]   clk_s;     // serial clock sync plus history
        logic [1:0]   dat_s;     // data sync
        logic [2:0]   usr_s;     // startup clock sync plus history
        logic [1:0]   stl_s;     // resolved status sync
        logic [CNT_W-1:0] cnt;   // general timer
        logic [CNT_W-1:0] bits;  // bits received
        logic [1:0]   falls;     // falling edges after done
        logic         st_low;    // status pulled low
        logic         done;      // load complete
        logic         bv;        // received bit strobe
        logic         bval;      // received bit
        logic [3:0]   rc_cnt;    // reconfigure strobe width
        logic [3:0]   wd_cnt;    // watchdog strobe width
        logic         wd_kick;   // watchdog kick pulse
    } psl_dev_t;

    psl_dev_t q, d;

    // width check for a strobe held high long enough
    function automatic logic [3:0] strb_cnt(input logic lvl,
                                            input logic [3:0] c);
        strb_cnt = !lvl ? 4'h0 : (c == 4'hf ? c : c + 4'h1);
    endfunction

    logic req_fall;   // request seen going low
    logic clk_rise;   // serial clock rising
    logic clk_fall;   // serial clock falling
    logic usr_rise;   // startup clock rising
    assign req_fall = q.req_s[2] & ~q.req_s[1];
    assign clk_rise = ~q.clk_s[2] & q.clk_s[1];
    assign clk_fall = q.clk_s[2] & ~q.clk_s[1];
    assign usr_rise = ~q.usr_s[2] & q.usr_s[1];

    // next state
    always_comb begin
        d = q;
        d.req_s = {q.req_s[1:0], link.cfg_req_n};
        d.clk_s = {q.clk_s[1:0], link.serial_cfg_clk};
        d.dat_s = {q.dat_s[0], link.serial_cfg_bit};
        d.usr_s = {q.usr_s[1:0], link.user_startup_clk};
        d.stl_s = {q.stl_s[0], link.status_n};
        d.bv = 1'b0;
        d.wd_kick = 1'b0;
        d.rc_cnt = strb_cnt(reconfig_strobe, q.rc_cnt);
        d.wd_cnt = strb_cnt(wdog_reset_strobe, q.wd_cnt);
        if (q.wd_cnt == 4'(STRB_MIN_CYC - 1) && wdog_reset_strobe) begin
            d.wd_kick = 1'b1;
        end
        case (q.st)
            S_POR: begin
                d.st_low = 1'b1;
                d.done = 1'b0;
                if (q.cnt >= CNT_W'(POR_CYC - 1)) begin
                    d.st = S_CLEAR;
                    d.cnt = '0;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            S_CLEAR: begin
                d.st_low = 1'b1;
                if (q.cnt < CNT_W'(STLOW_CYC)) begin
                    d.cnt = q.cnt + 1'b1;
                end else if (q.req_s[1]) begin
                    d.st_low = 1'b0;
                    d.st = S_LOAD;
                    d.bits = '0;
                end
            end
            S_LOAD: begin
                // status held low outside delays the load
                if (clk_rise && q.stl_s[1]) begin
                    d.bv = 1'b1;
                    d.bval = q.dat_s[1];
                    d.bits = q.bits + 1'b1;
                    if (q.bits == CNT_W'(BITS - 1)) begin
                        d.done = 1'b1;
                        d.st = S_START;
                        d.falls = '0;
                        d.cnt = '0;
                    end
                end
            end
            S_START: begin
                if (clk_fall) begin
                    d.falls = q.falls + 1'b1;
                    if (q.falls == 2'(START_EDGES - 1)) begin
                        d.st = S_INIT;
                        d.cnt = '0;
                    end
                end
            end
            S_INIT: begin
                if (startup_clk_opt) begin
                    if (usr_rise) begin
                        d.cnt = q.cnt + 1'b1;
                    end
                    if (q.cnt >= CNT_W'(INIT_CNT)) begin
                        d.st = S_USER;
                    end
                end else begin
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt >= CNT_W'(OSC_CYC - 1)) begin
                        d.st = S_USER;
                    end
                end
            end
            S_USER: begin
                d.st_low = 1'b0;
                d.done = 1'b1;
                if (q.rc_cnt == 4'(STRB_MIN_CYC - 1) && reconfig_strobe) begin
                    d.st = S_CLEAR;
                    d.st_low = 1'b1;
                    d.done = 1'b0;
                    d.cnt = '0;
                end
            end
            default: begin
                d.st = S_POR;
            end
        endcase
        // request low restarts, lines low fast
        if (req_fall || (!q.req_s[1] && q.st != S_POR)) begin
            d.st = S_CLEAR;
            d.st_low = 1'b1;
            d.done = 1'b0;
            d.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{st: S_POR, req_s: 3'h7, st_low: 1'b1, default: '0};
        end else if (clk_en) begin
            q <= d;
        end
    end

    // outputs from flops, init done also gated by init_done_opt
    assign link.status_n_o   = 1'b0;
    assign link.status_n_oe  = q.st_low;
    assign link.load_complete = q.done;
    assign user_mode = (q.st == S_USER);
    // init done low from load done until user mode
    // only pulled low when optioned, else it idles high
    assign init_done_n = ~(init_done_opt & q.done & (q.st != S_USER));
    assign data_pin_free = (q.st == S_USER);
    assign bit_valid = q.bv;
    assign bit_value = q.bval;
    assign wdog_kick = q.wd_kick;
endmodule
`default_nettype wire

//--- rtl/psl_host.sv
// host end of the passive serial loader: drives the bitstream
// assumes the device lines are asynchronous; clock made by a divider
`timescale 1ns/100ps
`default_nettype none
module psl_host
    import psl_pkg::*;
#(
    parameter int unsigned BITS     = 64,   // bitstream length
    parameter int unsigned TIMEOUT  = 4096  // tail cycles before a retry
) (
    // clock, reset, enable
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          clk_en,
    // link
    psl_link_if.host           link,
    // user side
    input  wire logic          start,
    input  wire logic          bit_in,
    output logic               bit_req,
    output logic               busy,
    output logic               loaded
);
    typedef enum logic [2:0] {
        H_IDLE, H_REQ, H_WAIT, H_GAP, H_SEND, H_TAIL, H_DONE
    } psl_host_st_t;

    typedef struct packed {
        psl_host_st_t st;
        logic [1:0]   st_s;     // status sync
        logic [1:0]   cd_s;     // done sync
        logic [CNT_W-1:0] cnt;  // timer / bit count
        logic [1:0]   div;      // clock divider
        logic         sclk;     // serial clock out
        logic         sbit;     // serial data out
        logic         req_n;    // request out
        logic [1:0]   falls;    // tail edges
        logic         breq;     // bit request pulse
        logic [1:0]   ucnt;     // free-running startup clock divider
    } psl_host_q_t;

    psl_host_q_t q, d;

    // next state
    always_comb begin
        d = q;
        d.st_s = {q.st_s[0], link.status_n};
        d.cd_s = {q.cd_s[0], link.load_complete};
        d.breq = 1'b0;
        // startup clock runs on after the serial clock is parked
        d.ucnt = q.ucnt + 1'b1;
        case (q.st)
            H_IDLE: begin
                d.sclk = 1'b0;
                if (start) begin
                    d.st = H_REQ;
                    d.req_n = 1'b0;
                    d.cnt = '0;
                end
            end
            H_REQ: begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt >= CNT_W'(CFG_REQ_LOW_CYC)) begin
                    d.req_n = 1'b1;
                    d.st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (q.st_s[1]) begin
                    d.st = H_GAP;
                    d.cnt = '0;
                end
            end
            H_GAP: begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt >= CNT_W'(ST_TO_CLK_CYC)) begin
                    d.st = H_SEND;
                    d.cnt = '0;
                    d.div = '0;
                    d.sbit = bit_in;
                    d.breq = 1'b1;
                end
            end
            H_SEND: begin
                d.div = q.div + 1'b1;
                if (q.div == 2'(CLK_HALF_CYC - 1)) begin
                    d.div = '0;
                    d.sclk = ~q.sclk;
                    if (q.sclk) begin
                        d.cnt = q.cnt + 1'b1;
                        if (q.cnt == CNT_W'(BITS - 1)) begin
                            d.st = H_TAIL;
                            d.falls = '0;
                            d.cnt = '0;
                        end else begin
                            d.sbit = bit_in;
                            d.breq = 1'b1;
                        end
                    end
                end
            end
            H_TAIL: begin
                d.div = q.div + 1'b1;
                d.cnt = q.cnt + 1'b1;
                if (q.div == 2'(CLK_HALF_CYC - 1)) begin
                    d.div = '0;
                    d.sclk = ~q.sclk;
                    if (q.sclk && q.cd_s[1]) begin
                        d.falls = q.falls + 1'b1;
                    end
                end
                if (q.falls == 2'(START_EDGES) && !q.sclk) begin
                    d.st = H_DONE;
                end else if (q.cnt >= CNT_W'(TIMEOUT)) begin
                    d.st = H_REQ;
                    // park low so the next load opens on a rise
                    d.sclk = 1'b0;
                    d.req_n = 1'b0;
                    d.cnt = '0;
                end
            end
            H_DONE: begin
                d.sclk = 1'b0;
                if (start) begin
                    d.st = H_REQ;
                    d.req_n = 1'b0;
                    d.cnt = '0;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{st: H_IDLE, req_n: 1'b1, default: '0};
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign link.cfg_req_n        = q.req_n;
    assign link.serial_cfg_clk   = q.sclk;
    assign link.serial_cfg_bit   = q.sbit;
    assign link.user_startup_clk = q.ucnt[1];
    assign bit_req = q.breq;
    assign busy    = (q.st != H_IDLE) && (q.st != H_DONE);
    assign loaded  = (q.st == H_DONE);
endmodule
`default_nettype wire

//--- tb/psl_checker.sv
// link checks for the passive serial loader, both ends being design code
// assumes the signals of one psl_link_if and the shared sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module psl_checker #(
    parameter int unsigned BITS  = 8,   // bitstream length
    parameter int unsigned STLOW = 20   // status pulse cycles
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // link
    input wire logic cfg_req_n,
    input wire logic status_n_oe,
    input wire logic status_n,
    input wire logic load_complete,
    input wire logic serial_cfg_clk,
    input wire logic serial_cfg_bit
);
    localparam int REQ_MIN = 50;   // 2 us of 40 ns cycles
    localparam int GAP_MIN = 50;   // status high to first edge
    logic        clk_q;            // last sampled serial clock
    logic [15:0] st_q;             // cycles status pulled low
    logic [15:0] rq_q;             // cycles request held low
    logic [15:0] rel_q;            // status low while request high
    logic [15:0] gap_q;            // cycles since status released
    logic [15:0] edge_q;           // rising edges since release
    logic        rs_q;             // request seen low since reset
    logic        rise;             // serial clock rising now
    assign rise = serial_cfg_clk & ~clk_q;
    // counters only; no saturation, runs stay far below wrap
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_q  <= 1'b0;
            st_q   <= 16'h0;
            rq_q   <= 16'h0;
            rel_q  <= 16'h0;
            gap_q  <= 16'h0;
            edge_q <= 16'h0;
            rs_q   <= 1'b0;
        end else begin
            clk_q  <= serial_cfg_clk;
            st_q   <= status_n_oe ? st_q + 16'h1 : 16'h0;
            rq_q   <= cfg_req_n ? 16'h0 : rq_q + 16'h1;
            // power-on status length is not bound by the release time
            rs_q   <= rs_q | ~cfg_req_n;
            rel_q  <= (status_n_oe && cfg_req_n && rs_q) ?
                      rel_q + 16'h1 : 16'h0;
            gap_q  <= status_n_oe ? 16'h0 : gap_q + 16'h1;
            edge_q <= status_n_oe ? 16'h0 : edge_q + {15'h0, rise};
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_req_clears_done: assert property (
        $fell(cfg_req_n) |-> ##[1:15] (!load_complete && status_n_oe))
        else $error("request low left done or status high");
    a_req_low_width: assert property (
        $rose(cfg_req_n) |-> rq_q >= REQ_MIN)
        else $error("request low pulse too short");
    a_status_width: assert property (
        $fell(status_n_oe) |-> st_q >= STLOW)
        else $error("status low pulse too short");
    a_status_release: assert property (
        (status_n_oe && cfg_req_n && rs_q) |-> rel_q < STLOW + 8)
        else $error("status held low too long");
    a_done_after_bits: assert property (
        $rose(load_complete) |-> (edge_q == BITS || edge_q == BITS + 1))
        else $error("done rose at wrong bit count");
    a_done_needs_status: assert property (
        $rose(load_complete) |-> (status_n && cfg_req_n))
        else $error("done rose during request or status low");
    a_first_edge_gap: assert property (
        (rise && edge_q == 16'h0) |-> gap_q >= GAP_MIN)
        else $error("first clock edge too soon after status");
    a_data_steady: assert property (
        rise |-> $stable(serial_cfg_bit))
        else $error("data moved at rising clock");
endmodule
`default_nettype wire

//--- tb/tb_passive_serial_config_loader.sv
// bench joining host and device ends of the passive serial loader
// assumes psl_pkg and psl_link_if compiled first; status pulled up
`timescale 1ns/100ps
`default_nettype none
module tb_passive_serial_config_loader;
    import psl_pkg::*;
    localparam int NB = 8;         // shortened bitstream
    localparam int PC = 20;        // shortened timer counts
    localparam int UP = 4;         // host startup clock period, cycles
    logic       sys_clk;           // 25 MHz clock
    logic       arst_n;            // async reset
    logic       start;             // host load request
    logic       bit_in;            // next bit for the host
    logic       ido;               // init done option
    logic       rcfg;              // reconfigure strobe
    logic       wdog;              // watchdog reset strobe
    logic       suo;               // startup clock option
    logic       hold;              // outside hold on the status line
    logic       bit_req, busy, loaded, um, idn, dpf, bv, bval, kick;
    logic [7:0] pat;               // bitstream being sent
    logic [3:0] tx_n = 4'h0;       // bits handed to the host
    logic [3:0] rx_n = 4'h0;       // bits seen at the device
    int         err_count;
    int         checks_done;
    psl_link_if lnk();
    // open-drain status: pulled up, device pulls low, bench may hold
    assign lnk.status_n = (lnk.status_n_oe ? lnk.status_n_o : 1'b1) & ~hold;
    assign bit_in = pat[tx_n[2:0]];
    psl_host #(.BITS(NB), .TIMEOUT(200)) psl_host_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .link(lnk.host), .start(start), .bit_in(bit_in),
        .bit_req(bit_req), .busy(busy), .loaded(loaded));
    psl_device #(.BITS(NB), .POR_CYC(PC), .STLOW_CYC(PC),
        .OSC_CYC(PC), .INIT_CNT(PC)) psl_device_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .link(lnk.dev), .startup_clk_opt(suo), .init_done_opt(ido),
        .reconfig_strobe(rcfg), .wdog_reset_strobe(wdog),
        .user_mode(um), .init_done_n(idn), .data_pin_free(dpf),
        .bit_valid(bv), .bit_value(bval), .wdog_kick(kick));
    psl_checker #(.BITS(NB), .STLOW(PC)) psl_checker_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .cfg_req_n(lnk.cfg_req_n),
        .status_n_oe(lnk.status_n_oe), .status_n(lnk.status_n),
        .load_complete(lnk.load_complete),
        .serial_cfg_clk(lnk.serial_cfg_clk),
        .serial_cfg_bit(lnk.serial_cfg_bit));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk_bit(input logic got, input logic exp, string m);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic chk_num(input int got, input int lo, input int hi,
                           string m);
        chk_bit(got >= lo && got <= hi, 1'b1, m);
    endtask
    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // which design output, or bench bit count, a wait watches
    function automatic logic pick(input int w);
        case (w)
            0: return lnk.load_complete;
            1: return um;
            2: return lnk.status_n;
            3: return kick;
            4: return lnk.cfg_req_n;
            default: return rx_n == 4'h5;
        endcase
    endfunction
    // bounded wait; running out counts and closes the run
    task automatic wait_on(input int w, input logic v, input int lim,
                           output int n);
        n = 0;
        while (pick(w) !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim) begin
            chk_bit(1'b0, 1'b1, "wait limit reached");
            end_of_test();
        end
    endtask
    // output must not reach v for cyc cycles
    task automatic stay_off(input int w, input logic v, input int cyc);
        logic hit;
        hit = 1'b0;
        repeat (cyc) begin
            @(posedge sys_clk);
            hit = hit | (pick(w) === v);
        end
        chk_bit(hit, 1'b0, "output moved on short strobe");
    endtask
    // host bit feed and device bit capture, both restart with a load
    always @(posedge sys_clk) begin
        if (lnk.cfg_req_n === 1'b0) begin
            tx_n <= 4'h0;
            rx_n <= 4'h0;
        end else begin
            if (bit_req === 1'b1) tx_n <= tx_n + 4'h1;
            if (bv === 1'b1) begin
                // first bit sent comes out first
                chk_bit(bval, pat[rx_n[2:0]], "received bit wrong");
                rx_n <= rx_n + 4'h1;
            end
        end
    end
    task automatic sc_power_up();
        int n;
        repeat (4) @(posedge sys_clk);
        chk_bit(lnk.status_n, 1'b0, "status high in power-on");
        chk_bit(lnk.load_complete, 1'b0, "done high at power-up");
        wait_on(2, 1'b1, 400, n);
        chk_num(n + 4, PC, 4 * PC, "power-on status length");
    endtask
    task automatic sc_load(input logic opt, input logic uopt,
                           input logic [7:0] p);
        int  n;
        logic s;
        pat   <= p;
        ido   <= opt;
        suo   <= uopt;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        wait_on(2, 1'b0, 20, n);
        chk_bit(lnk.load_complete, 1'b0, "done high in load");
        wait_on(0, 1'b1, 2000, n);
        // last bit and done share an edge: let the bit count land
        @(posedge sys_clk);
        chk_num(rx_n, NB, NB, "bit count at done");
        chk_bit(idn, ~opt, "init done level in init");
        chk_bit(busy, 1'b1, "host idle before tail");
        wait_on(1, 1'b1, 200, n);
        if (uopt) begin
            chk_num(n, UP * PC, UP * PC + 40, "startup clock init");
        end else begin
            chk_num(n, PC, 50, "done to user mode");
        end
        chk_bit(lnk.cfg_req_n, 1'b1, "request low in user");
        chk_bit(lnk.status_n, 1'b1, "status low in user");
        chk_bit(lnk.load_complete, 1'b1, "done low in user");
        chk_bit(dpf, 1'b1, "data pin kept");
        chk_bit(idn, 1'b1, "init done low in user");
        chk_bit(loaded, 1'b1, "host not loaded");
        chk_bit(busy, 1'b0, "host busy after load");
        s = lnk.serial_cfg_clk;
        repeat (16) @(posedge sys_clk);
        chk_bit(lnk.serial_cfg_clk, s, "clock not parked");
    endtask
    task automatic sc_strobes();
        int n;
        wdog <= 1'b1;
        repeat (6) @(posedge sys_clk);
        wdog <= 1'b0;
        stay_off(3, 1'b1, 30);
        wdog <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wdog <= 1'b0;
        wait_on(3, 1'b1, 30, n);
        rcfg <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rcfg <= 1'b0;
        stay_off(0, 1'b0, 30);
        rcfg <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rcfg <= 1'b0;
        wait_on(0, 1'b0, 30, n);
        chk_bit(um, 1'b0, "user mode kept on restart");
    endtask
    // status held low over the last bits: done stays low, host retries
    task automatic sc_retry();
        int n;
        pat   <= 8'h69;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        wait_on(5, 1'b1, 2000, n);
        hold <= 1'b1;
        wait_on(4, 1'b0, 400, n);
        hold <= 1'b0;
        chk_bit(lnk.load_complete, 1'b0, "done rose on partial load");
        wait_on(0, 1'b1, 2000, n);
        @(posedge sys_clk);
        chk_num(rx_n, NB, NB, "bit count after retry");
    endtask
    initial begin
        arst_n = 1'b0;
        start  = 1'b0;
        ido    = 1'b1;
        rcfg   = 1'b0;
        wdog   = 1'b0;
        suo    = 1'b0;
        hold   = 1'b0;
        pat    = 8'hb4;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        sc_power_up();
        sc_load(1'b1, 1'b0, 8'hb4);
        sc_load(1'b0, 1'b0, 8'h4b);
        sc_strobes();
        sc_load(1'b1, 1'b1, 8'h96);
        sc_retry();
        end_of_test();
    end
    // hang guard far above the expected run length
    initial begin
        #2000000;
        chk_bit(1'b0, 1'b1, "run timed out");
        end_of_test();
    end
endmodule
`default_nettype wire
